// ---- hdl/vcr_map.svh ----
// Register offsets, field positions, reset values for the decoder control register bank
`ifndef VCR_MAP_SVH
`define VCR_MAP_SVH

// Byte offsets on the APB bus
`define VCR_OFF_FINAL_METRIC   12'h000
`define VCR_OFF_BEST_STATE     12'h004
`define VCR_OFF_EXEC_CMD       12'h008
`define VCR_OFF_MEM_FORMAT     12'h00c
`define VCR_OFF_STATUS0        12'h010
`define VCR_OFF_FAULT          12'h014

// Result field positions
`define VCR_MIN_LSB            16
`define VCR_MAX_LSB            0
`define VCR_METRIC_W           13
`define VCR_QUALITY_BIT        16
`define VCR_INDEX_W            8

// Command field and codes
`define VCR_CMD_W              4
`define VCR_CMD_NONE           4'h0
`define VCR_CMD_START          4'h1
`define VCR_CMD_PAUSE          4'h2
`define VCR_CMD_STEP           4'h3
`define VCR_CMD_RESUME         4'h4
`define VCR_CMD_STOP           4'h5

// Format bits
`define VCR_FMT_BM_BIT         0
`define VCR_FMT_SD_BIT         1

// Status bits
`define VCR_ST_PAUSED          0
`define VCR_ST_RUNNING         1
`define VCR_ST_ERROR           2
`define VCR_ST_AWAIT_CFG       3
`define VCR_ST_IN_EMPTY        4
`define VCR_ST_OUT_FULL        5
`define VCR_ST_DEBUG_HALT      6
`define VCR_ST_SYMCNT_LSB      12
`define VCR_SYMCNT_W           17

// Fault code width
`define VCR_FAULT_W            7

// Reset value of the input-queue-empty flag
`define VCR_IN_EMPTY_RST       1'b1

`endif

// ---- hdl/vcr_pkg.sv ----
// Types shared by the decoder control register bank
package vcr_pkg;

  // Result words delivered by the decoding datapath
  typedef struct packed {
    logic [12:0] final_min_metric;
    logic [12:0] final_max_metric;
    logic        frame_quality_flag;
    logic [7:0]  best_state_index;
  } vcr_result_t;

  // Live conditions and events reported by the datapath
  typedef struct packed {
    logic        window_done;
    logic        channel_done;
    logic        input_queue_empty;
    logic        output_queue_full;
    logic        debug_halt_flag;
    logic        fault_event;
    logic [6:0]  fault_code;
    logic [16:0] processed_symbol_count;
  } vcr_dp_status_t;

  // Controls driven to the datapath
  typedef struct packed {
    logic start;
    logic traceback_go;
    logic soft_reset;
    logic run_enable;
    logic soft_decision_layout;
    logic branch_metric_layout;
  } vcr_dp_ctrl_t;

  // Sequencer states
  typedef enum logic [1:0] {
    VCR_IDLE,
    VCR_RUN_FREE,
    VCR_RUN_STEP,
    VCR_PAUSED
  } vcr_state_t;

endpackage

// ---- hdl/vcr_sync.sv ----
// Three-stage synchroniser with agreement filter for asynchronous pin levels
`timescale 1ns/100ps
`default_nettype none
module vcr_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  // Shift chain; stage1 feeds stage2 only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Accept a new level only once the later stages agree, filtering one-cycle glitches
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync_out <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (stage2[i] == stage3[i]) begin
          sync_out[i] <= stage3[i];
        end
      end
    end
  end

endmodule
`default_nettype wire

// ---- hdl/vcr_ctrl_regs.sv ----
// Result, command, format and status register bank of the Viterbi decoder coprocessor
//
// Overview of operation
// - Reserved bits read as zero; writes to them have no effect.
// - Result word 0 bits 28:16 hold the 13-bit minimum final metric.
// - Result word 0 bits 12:0 hold the maximum metric of the last stage.
// - Result word 1 bit 16: 0 poor frame, 1 good frame.
// - Quality flag meaningful only with threshold logic enabled; software ignores it otherwise.
// - Result word 1 bits 7:0 report index of the final best state.
// - Command in bits 3:0; zero is no instruction, 6h and up reserved.
// - Command 1h starts decoding in normal mode.
// - Command 2h pauses after current window metrics, before its traceback.
// - Command 3h resumes, traces back, pauses after next window metrics.
// - Command 4h resumes, traces back, runs to completion without pausing.
// - Command 5h stops and resets registers except command and format.
// - Format register takes effect only when the system runs big-endian.
// - Format bit 1: soft-decision output 0 packed words, 1 native bytes.
// - Format bit 0: branch metric input 0 packed words, 1 native bytes.
// - Status flags at bits 6..0; input-empty resets to 1, others 0.
// - Error flag clears when software reads the fault register.
// - Awaiting-configuration flag sets whenever a channel finishes decoding.
// - Paused flag acknowledges pause/resume; also set on queue empty or full while running.
`timescale 1ns/100ps
`default_nettype none
`include "vcr_map.svh"
module vcr_ctrl_regs
  import vcr_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           resetn,
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [11:0]    paddr,
  input  wire logic [31:0]    pwdata,
  output var  logic [31:0]    prdata,
  output var  logic           pready,
  output var  logic           pslverr,
  input  wire logic           big_endian_pin,
  input  wire logic           result_valid,
  input  wire vcr_result_t    result_in,
  input  wire vcr_dp_status_t dp_status,
  output var  vcr_dp_ctrl_t   dp_ctrl
);

  // Register state
  logic [12:0]  final_min_metric;
  logic [12:0]  final_max_metric;
  logic         frame_quality_flag;
  logic [7:0]   best_state_index;
  logic [3:0]   execution_command;
  logic         soft_decision_layout;
  logic         branch_metric_layout;
  logic         error_flag;
  logic         awaiting_configuration;
  logic         input_queue_empty;
  logic         output_queue_full;
  logic         debug_halt_flag;
  logic [16:0]  processed_symbol_count;
  logic [6:0]   fault_code;
  vcr_state_t   state;
  logic         big_endian;

  // Bus decode
  logic         setup_phase;
  logic         wr_access;
  logic         rd_access;
  logic         addr_mapped;
  logic [31:0]  read_mux;
  logic         cmd_write;
  logic [3:0]   cmd_code;
  logic         soft_reset;
  logic         paused_flag;
  logic         running_flag;
  logic         start_pulse;
  logic         trace_pulse;

  // Big-endian strap arrives from a pin, so it is synchronised
  vcr_sync #(
    .W (1)
  ) u_endian_sync (
    .clk      (clk),
    .resetn   (resetn),
    .async_in (big_endian_pin),
    .sync_out (big_endian)
  );

  // APB phases; zero-wait slave so every access ends on its first access cycle
  // Ready follows the master's own strobes, so a slow master never sees a stale ready
  // Unmapped offsets still complete, but flag an error instead of hanging the bus
  assign setup_phase = psel & ~penable;
  assign wr_access   = psel & penable & pwrite;
  assign rd_access   = psel & penable & ~pwrite;
  assign pready      = psel & penable;
  assign pslverr     = psel & penable & ~addr_mapped;

  // Command decode from a write to the execution register
  assign cmd_write  = wr_access & (paddr == `VCR_OFF_EXEC_CMD);
  assign cmd_code   = pwdata[`VCR_CMD_W-1:0];
  assign soft_reset = cmd_write & (cmd_code == `VCR_CMD_STOP);

  // Address map check
  always_comb begin
    case (paddr)
      `VCR_OFF_FINAL_METRIC,
      `VCR_OFF_BEST_STATE,
      `VCR_OFF_EXEC_CMD,
      `VCR_OFF_MEM_FORMAT,
      `VCR_OFF_STATUS0,
      `VCR_OFF_FAULT:       addr_mapped = 1'b1;
      default:              addr_mapped = 1'b0;
    endcase
  end

  // Read data assembly; unused positions stay zero
  always_comb begin
    read_mux = 32'h0000_0000;
    case (paddr)
      `VCR_OFF_FINAL_METRIC: begin
        read_mux[`VCR_MIN_LSB +: `VCR_METRIC_W] = final_min_metric;
        read_mux[`VCR_MAX_LSB +: `VCR_METRIC_W] = final_max_metric;
      end
      `VCR_OFF_BEST_STATE: begin
        read_mux[`VCR_QUALITY_BIT] = frame_quality_flag;
        read_mux[`VCR_INDEX_W-1:0] = best_state_index;
      end
      `VCR_OFF_EXEC_CMD: begin
        read_mux[`VCR_CMD_W-1:0] = execution_command;
      end
      `VCR_OFF_MEM_FORMAT: begin
        read_mux[`VCR_FMT_SD_BIT] = soft_decision_layout;
        read_mux[`VCR_FMT_BM_BIT] = branch_metric_layout;
      end
      `VCR_OFF_STATUS0: begin
        read_mux[`VCR_ST_SYMCNT_LSB +: `VCR_SYMCNT_W] = processed_symbol_count;
        read_mux[`VCR_ST_DEBUG_HALT] = debug_halt_flag;
        read_mux[`VCR_ST_OUT_FULL]   = output_queue_full;
        read_mux[`VCR_ST_IN_EMPTY]   = input_queue_empty;
        read_mux[`VCR_ST_AWAIT_CFG]  = awaiting_configuration;
        read_mux[`VCR_ST_ERROR]      = error_flag;
        read_mux[`VCR_ST_RUNNING]    = running_flag;
        read_mux[`VCR_ST_PAUSED]     = paused_flag;
      end
      `VCR_OFF_FAULT: begin
        read_mux[`VCR_FAULT_W-1:0] = fault_code;
      end
      default: begin
        read_mux = 32'h0000_0000;
      end
    endcase
  end

  // Read data captured in setup so the access cycle shows a flop output
  // Costs one flop stage, keeps the decode mux off the bus output path
  // Fault read clears the error only at the access edge, after the capture
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      prdata <= read_mux;
    end
  end

  // Sequencer: start, pause at window end, single step, free resume, stop
  // Idle waits for a start; run-free decodes with no pause pending
  // Run-step holds a pending pause that lands at the next window end
  // Paused sits before traceback until a step or resume arrives
  // A fault also parks the decoder in pause so software can inspect it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= VCR_IDLE;
    end else if (soft_reset) begin
      state <= VCR_IDLE;
    end else if (cmd_write) begin
      case (cmd_code)
        `VCR_CMD_START: begin
          if (state == VCR_IDLE) begin
            state <= VCR_RUN_FREE;
          end
        end
        `VCR_CMD_PAUSE: begin
          if (state == VCR_RUN_FREE) begin
            state <= VCR_RUN_STEP;
          end
        end
        `VCR_CMD_STEP: begin
          if (state == VCR_PAUSED) begin
            state <= VCR_RUN_STEP;
          end
        end
        `VCR_CMD_RESUME: begin
          if (state == VCR_PAUSED) begin
            state <= VCR_RUN_FREE;
          end
        end
        default: begin
          state <= state;
        end
      endcase
    end else begin
      case (state)
        VCR_RUN_FREE,
        VCR_RUN_STEP: begin
          if (dp_status.channel_done) begin
            state <= VCR_IDLE;
          end else if (dp_status.fault_event) begin
            state <= VCR_PAUSED;
          end else if (state == VCR_RUN_STEP && dp_status.window_done) begin
            state <= VCR_PAUSED;
          end
        end
        VCR_IDLE,
        VCR_PAUSED: begin
          state <= state;
        end
        default: begin
          state <= VCR_IDLE;
        end
      endcase
    end
  end

  // Single-cycle command pulses toward the datapath
  assign start_pulse = cmd_write & (cmd_code == `VCR_CMD_START) & (state == VCR_IDLE);
  assign trace_pulse = cmd_write & (state == VCR_PAUSED) &
                       ((cmd_code == `VCR_CMD_STEP) | (cmd_code == `VCR_CMD_RESUME));

  // Paused while held, or while a queue stalls a running decode
  assign running_flag = (state == VCR_RUN_FREE) | (state == VCR_RUN_STEP);
  assign paused_flag  = (state == VCR_PAUSED) |
                        (running_flag & (input_queue_empty | output_queue_full));

  // Last command written; exempt from the stop reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      execution_command <= `VCR_CMD_NONE;
    end else if (cmd_write) begin
      execution_command <= cmd_code;
    end
  end

  // Memory format selection; exempt from the stop reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      soft_decision_layout <= 1'b0;
      branch_metric_layout <= 1'b0;
    end else if (wr_access && paddr == `VCR_OFF_MEM_FORMAT) begin
      soft_decision_layout <= pwdata[`VCR_FMT_SD_BIT];
      branch_metric_layout <= pwdata[`VCR_FMT_BM_BIT];
    end
  end

  // Result capture wins over a software write in the same cycle
  // A decode result is never lost to a racing write of result word 0; a racing stop still clears it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      final_min_metric   <= 13'h0000;
      final_max_metric   <= 13'h0000;
      frame_quality_flag <= 1'b0;
      best_state_index   <= 8'h00;
    end else if (soft_reset) begin
      final_min_metric   <= 13'h0000;
      final_max_metric   <= 13'h0000;
      frame_quality_flag <= 1'b0;
      best_state_index   <= 8'h00;
    end else if (result_valid) begin
      final_min_metric   <= result_in.final_min_metric;
      final_max_metric   <= result_in.final_max_metric;
      frame_quality_flag <= result_in.frame_quality_flag;
      best_state_index   <= result_in.best_state_index;
    end else if (wr_access && paddr == `VCR_OFF_FINAL_METRIC) begin
      final_min_metric   <= pwdata[`VCR_MIN_LSB +: `VCR_METRIC_W];
      final_max_metric   <= pwdata[`VCR_MAX_LSB +: `VCR_METRIC_W];
    end
  end

  // Error flag: a new fault wins over the clearing read
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      error_flag <= 1'b0;
      fault_code <= 7'h00;
    end else if (soft_reset) begin
      error_flag <= 1'b0;
      fault_code <= 7'h00;
    end else if (dp_status.fault_event) begin
      error_flag <= 1'b1;
      fault_code <= dp_status.fault_code;
    end else if (rd_access && paddr == `VCR_OFF_FAULT) begin
      error_flag <= 1'b0;
    end
  end

  // Awaiting configuration: set at channel end, cleared by a start
  // A channel end in the same cycle as a start leaves the flag set
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      awaiting_configuration <= 1'b0;
    end else if (soft_reset) begin
      awaiting_configuration <= 1'b0;
    end else if (dp_status.channel_done) begin
      awaiting_configuration <= 1'b1;
    end else if (start_pulse) begin
      awaiting_configuration <= 1'b0;
    end
  end

  // Live queue and debug flags, registered so reset values are defined
  // Copies lag the datapath by one cycle; a stop reloads the reset levels
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      input_queue_empty      <= `VCR_IN_EMPTY_RST;
      output_queue_full      <= 1'b0;
      debug_halt_flag        <= 1'b0;
      processed_symbol_count <= 17'h00000;
    end else if (soft_reset) begin
      input_queue_empty      <= `VCR_IN_EMPTY_RST;
      output_queue_full      <= 1'b0;
      debug_halt_flag        <= 1'b0;
      processed_symbol_count <= 17'h00000;
    end else begin
      input_queue_empty      <= dp_status.input_queue_empty;
      output_queue_full      <= dp_status.output_queue_full;
      debug_halt_flag        <= dp_status.debug_halt_flag;
      processed_symbol_count <= dp_status.processed_symbol_count;
    end
  end

  // Datapath controls; formats forced to packed words in little-endian systems
  // The strap passes the synchroniser, so a strap change takes a few cycles here
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dp_ctrl <= '0;
    end else begin
      dp_ctrl.start                <= start_pulse;
      dp_ctrl.traceback_go         <= trace_pulse;
      dp_ctrl.soft_reset           <= soft_reset;
      dp_ctrl.run_enable           <= running_flag & ~soft_reset;
      dp_ctrl.soft_decision_layout <= big_endian & soft_decision_layout;
      dp_ctrl.branch_metric_layout <= big_endian & branch_metric_layout;
    end
  end

endmodule
`default_nettype wire

// ---- bench/vcr_ctrl_regs_sva.sv ----
// Port-level assertions for the decoder control register bank
`timescale 1ns/100ps
`default_nettype none
module vcr_ctrl_regs_sva
  import vcr_pkg::*;
(
  input wire logic         clk,
  input wire logic         resetn,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [11:0]  paddr,
  input wire logic [31:0]  pwdata,
  input wire logic [31:0]  prdata,
  input wire logic         big_endian_pin,
  input wire vcr_dp_ctrl_t dp_ctrl
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Access-phase qualifiers; command writes only at the execution offset
  logic rd;
  logic wr;
  assign rd = psel && penable && !pwrite;
  assign wr = psel && penable && pwrite && paddr == 12'h008;
  property p_rsv_res0; rd && paddr == 12'h000 |-> prdata[31:29] == 3'h0 && prdata[15:13] == 3'h0; endproperty
  a_rsv_res0: assert property (p_rsv_res0) else $error("result0 reserved bits set");
  property p_rsv_res1; rd && paddr == 12'h004 |-> prdata[31:17] == 15'h0 && prdata[15:8] == 8'h0; endproperty
  a_rsv_res1: assert property (p_rsv_res1) else $error("result1 reserved bits set");
  property p_rsv_cmd; rd && paddr == 12'h008 |-> prdata[31:4] == 28'h0; endproperty
  a_rsv_cmd: assert property (p_rsv_cmd) else $error("command reserved bits set");
  property p_rsv_fmt; rd && paddr == 12'h00c |-> prdata[31:2] == 30'h0; endproperty
  a_rsv_fmt: assert property (p_rsv_fmt) else $error("format reserved bits set");
  property p_rsv_st; rd && paddr == 12'h010 |-> prdata[31:29] == 3'h0 && prdata[11:7] == 5'h0; endproperty
  a_rsv_st: assert property (p_rsv_st) else $error("status reserved bits set");
  // Start and traceback pulses must trace back to the matching command write; a stop write must raise soft reset next cycle
  property p_start; dp_ctrl.start |-> $past(wr && pwdata[3:0] == 4'h1); endproperty
  a_start: assert property (p_start) else $error("start without start command");
  property p_tb_go; dp_ctrl.traceback_go |-> $past(wr && pwdata[3:0] inside {4'h3, 4'h4}); endproperty
  a_tb_go: assert property (p_tb_go) else $error("traceback without resume command");
  property p_stop; wr && pwdata[3:0] == 4'h5 |=> dp_ctrl.soft_reset; endproperty
  a_stop: assert property (p_stop) else $error("stop gave no soft reset");
  // Little-endian for long enough forces both layouts off
  property p_le; !big_endian_pin [*8] |=> !dp_ctrl.soft_decision_layout && !dp_ctrl.branch_metric_layout;
  endproperty
  a_le: assert property (p_le) else $error("layout active in little-endian");
endmodule
`default_nettype wire

// ---- bench/vcr_dp_model.sv ----
// Behavioural decoding datapath facing the register bank
`timescale 1ns/100ps
`default_nettype none
module vcr_dp_model
  import vcr_pkg::*;
#(
  parameter logic [16:0] SC = 17'h0a5c3
)(
  input  wire logic           clk,
  input  wire logic           resetn,
  input  wire vcr_dp_ctrl_t   dp_ctrl,
  output var  logic           result_valid,
  output var  vcr_result_t    result_in,
  output var  vcr_dp_status_t dp_status
);
  int n_start;
  int n_tb;
  int n_rst;
  // Idle levels; input queue starts empty
  initial begin
    result_valid = 1'b0;
    result_in = '0;
    dp_status = '0;
    dp_status.input_queue_empty = 1'b1;
    dp_status.processed_symbol_count = SC;
  end
  // Count control pulses; queue fills on start, empties on soft reset
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      n_start <= 0;
      n_tb <= 0;
      n_rst <= 0;
    end else begin
      n_start <= n_start + int'(dp_ctrl.start);
      n_tb <= n_tb + int'(dp_ctrl.traceback_go);
      n_rst <= n_rst + int'(dp_ctrl.soft_reset);
      if (dp_ctrl.start)
        dp_status.input_queue_empty <= 1'b0;
      if (dp_ctrl.soft_reset)
        dp_status.input_queue_empty <= 1'b1;
    end
  end
  // One result word pulse; data scrambled once the pulse is over
  task automatic push(input vcr_result_t r);
    result_in <= r;
    result_valid <= 1'b1;
    @(posedge clk);
    result_in <= ~r;
    result_valid <= 1'b0;
    @(posedge clk);
  endtask
  // Event pulse: bit0 window, bit1 channel, bit2 fault
  task automatic ev(input logic [2:0] k, input logic [6:0] c);
    dp_status.window_done <= k[0];
    dp_status.channel_done <= k[1];
    dp_status.fault_event <= k[2];
    dp_status.fault_code <= c;
    @(posedge clk);
    dp_status.window_done <= 1'b0;
    dp_status.channel_done <= 1'b0;
    dp_status.fault_event <= 1'b0;
    dp_status.fault_code <= ~c;
    @(posedge clk);
  endtask
  // Input queue level while running
  task automatic set_ie(input logic v);
    dp_status.input_queue_empty <= v;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the decoder control register bank
`timescale 1ns/100ps
`default_nettype none
module tb;
  import vcr_pkg::*;
  localparam logic [16:0] SC = 17'h0a5c3;
  logic           clk = 1'b0;
  logic           resetn = 1'b0;
  logic           psel = 1'b0;
  logic           penable = 1'b0;
  logic           pwrite = 1'b0;
  logic           big_endian_pin = 1'b0;
  logic [11:0]    paddr = 12'h000;
  logic [31:0]    pwdata = 32'h0;
  logic [31:0]    prdata;
  logic [31:0]    rdat;
  logic           pready;
  logic           pslverr;
  logic           last_err;
  logic           result_valid;
  vcr_result_t    result_in;
  vcr_dp_status_t dp_status;
  vcr_dp_ctrl_t   dp_ctrl;
  int             miscompares = 0;
  int             cmp_count = 0;
  int             c;

  always #4 clk = ~clk;

  vcr_ctrl_regs i_dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .big_endian_pin(big_endian_pin), .result_valid(result_valid), .result_in(result_in),
    .dp_status(dp_status), .dp_ctrl(dp_ctrl));
  vcr_dp_model #(.SC(SC)) i_dp (.clk(clk), .resetn(resetn), .dp_ctrl(dp_ctrl),
    .result_valid(result_valid), .result_in(result_in), .dp_status(dp_status));

  // Verdict and end of run, shared with the watchdog
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; request held until pready is seen at an edge, only the watchdog ends a wait
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  function automatic logic [31:0] st(input logic [6:0] f);
    return {3'h0, SC, 5'h0, f};
  endfunction
  function automatic logic [31:0] lay();
    return {30'h0, dp_ctrl.soft_decision_layout, dp_ctrl.branch_metric_layout};
  endfunction

  // Watchdog, well beyond the expected run
  initial begin
    #200000;
    miscompares++;
    wrap_up();
  end

  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rc(12'h010, st(7'h10));
    rc(12'h008, 32'h0);
    $display("test reset done");
    i_dp.push({13'h1abc, 13'h0123, 1'b1, 8'h5a});
    rc(12'h000, 32'h1abc0123);
    rc(12'h004, 32'h0001005a);
    i_dp.push({13'h0001, 13'h1fff, 1'b0, 8'hff});
    rc(12'h004, 32'h000000ff);
    wr(12'h000, 32'hffffffff);
    rc(12'h000, 32'h1fff1fff);
    wr(12'h004, 32'h0);
    rc(12'h004, 32'h000000ff);
    wr(12'h008, 32'hfffffff0);
    rc(12'h008, 32'h0);
    wr(12'h00c, 32'hffffffff);
    rc(12'h00c, 32'h3);
    apb(1'b0, 12'h018, 32'h0);
    chk(rdat, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    $display("test results done");
    wr(12'h008, 32'h1);
    @(posedge clk);
    chk(i_dp.n_start, 32'h1);
    rc(12'h010, st(7'h02));
    chk({31'h0, dp_ctrl.run_enable}, 32'h1);
    for (c = 0; c < 16; c++) begin
      if (c == 0 || c > 5) begin
        wr(12'h008, 32'(c));
        rc(12'h008, 32'(c));
        rc(12'h010, st(7'h02));
      end
    end
    i_dp.set_ie(1'b1);
    rc(12'h010, st(7'h13));
    i_dp.set_ie(1'b0);
    rc(12'h010, st(7'h02));
    i_dp.dp_status.output_queue_full <= 1'b1;
    i_dp.dp_status.debug_halt_flag <= 1'b1;
    @(posedge clk);
    rc(12'h010, st(7'h63));
    i_dp.dp_status.output_queue_full <= 1'b0;
    i_dp.dp_status.debug_halt_flag <= 1'b0;
    @(posedge clk);
    $display("test start done");
    wr(12'h008, 32'h2);
    rc(12'h010, st(7'h02));
    i_dp.ev(3'b001, 7'h0);
    rc(12'h010, st(7'h01));
    chk({31'h0, dp_ctrl.run_enable}, 32'h0);
    wr(12'h008, 32'h3);
    rc(12'h010, st(7'h02));
    chk(i_dp.n_tb, 32'h1);
    i_dp.ev(3'b001, 7'h0);
    rc(12'h010, st(7'h01));
    wr(12'h008, 32'h4);
    i_dp.ev(3'b001, 7'h0);
    chk(i_dp.n_tb, 32'h2);
    rc(12'h010, st(7'h02));
    $display("test pause done");
    i_dp.ev(3'b100, 7'h2a);
    rc(12'h010, st(7'h05));
    rc(12'h014, 32'h2a);
    rc(12'h010, st(7'h01));
    wr(12'h008, 32'h4);
    i_dp.ev(3'b010, 7'h0);
    rc(12'h010, st(7'h08));
    wr(12'h008, 32'h1);
    rc(12'h010, st(7'h02));
    $display("test fault done");
    wr(12'h00c, 32'h3);
    wr(12'h008, 32'h5);
    rc(12'h000, 32'h0);
    chk(i_dp.n_rst, 32'h1);
    rc(12'h004, 32'h0);
    rc(12'h010, st(7'h10));
    rc(12'h00c, 32'h3);
    rc(12'h008, 32'h5);
    $display("test stop done");
    chk(lay(), 32'h0);
    big_endian_pin <= 1'b1;
    repeat (8) @(posedge clk);
    chk(lay(), 32'h3);
    wr(12'h00c, 32'h1);
    @(posedge clk);
    chk(lay(), 32'h1);
    wr(12'h00c, 32'h2);
    @(posedge clk);
    chk(lay(), 32'h2);
    big_endian_pin <= 1'b0;
    repeat (8) @(posedge clk);
    chk(lay(), 32'h0);
    $display("test format done");
    wrap_up();
  end
endmodule

bind vcr_ctrl_regs vcr_ctrl_regs_sva i_sva (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .big_endian_pin(big_endian_pin),
  .dp_ctrl(dp_ctrl));
`default_nettype wire
